/* uart_mss_channel.sv */
// one serial channel: cts change detect, modem status byte, scratch, auto cts pause
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "uart_mss_defs.svh"

module uart_mss_channel
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and transmitter
	input wire logic cts_pin_n,
	input wire logic tx_active,
	output logic tx_halt,
	// register access
	input wire logic rd_msr,
	input wire logic wr_scr,
	input wire logic wr_ier,
	input wire logic wr_efr,
	input wire logic wr_mcr,
	input wire uart_mss_pkg::byte_type wr_data,
	output uart_mss_pkg::byte_type modem_line_status,
	output uart_mss_pkg::byte_type scratch_pad,
	output uart_mss_pkg::byte_type interrupt_enable_register,
	output uart_mss_pkg::byte_type enhanced_feature_register,
	output uart_mss_pkg::byte_type modem_control_register,
	output logic ms_irq
);
	import uart_mss_pkg::*;

	logic cts_meta_reg;
	logic cts_sync_reg;
	logic cts_prev_reg;
	logic delta_cts_reg;
	byte_type scr_reg;
	byte_type ier_reg;
	byte_type efr_reg;
	byte_type mcr_reg;
	tx_flow_type flow_reg;
	tx_flow_type flow_next;
	logic auto_cts;
	logic cts_change;
	// unused modem inputs stay at the inactive pin level
	logic dsr_pin_n;
	logic ri_pin_n;
	logic cd_pin_n;

	assign dsr_pin_n = `MSS_PIN_IDLE;
	assign ri_pin_n = `MSS_PIN_IDLE;
	assign cd_pin_n = `MSS_PIN_IDLE;

	// two flops before anything looks at the pin
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cts_meta_reg <= `MSS_PIN_IDLE;
			cts_sync_reg <= `MSS_PIN_IDLE;
			cts_prev_reg <= `MSS_PIN_IDLE;
		end
		else
		begin
			cts_meta_reg <= cts_pin_n;
			cts_sync_reg <= cts_meta_reg;
			cts_prev_reg <= cts_sync_reg;
		end
	end

	assign cts_change = cts_sync_reg ^ cts_prev_reg;

	// a change in the read cycle survives the clear
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			delta_cts_reg <= 1'b0;
		else if (cts_change)
			delta_cts_reg <= 1'b1;
		else if (rd_msr)
			delta_cts_reg <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			scr_reg <= `MSS_BYTE_ZERO;
		else if (wr_scr)
			scr_reg <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ier_reg <= `MSS_BYTE_ZERO;
			efr_reg <= `MSS_BYTE_ZERO;
			mcr_reg <= `MSS_BYTE_ZERO;
		end
		else
		begin
			if (wr_ier)
				ier_reg <= wr_data;
			if (wr_efr)
				efr_reg <= wr_data;
			if (wr_mcr)
				mcr_reg <= wr_data;
		end
	end

	assign auto_cts = efr_reg[`EFR_AUTO_CTS_BIT] & mcr_reg[`MCR_FLOW_SEL_BIT];

	// a stop request never cuts a character; it waits in drain until the shifter idles
	always_comb
	begin
		flow_next = flow_reg;
		case (flow_reg)
			TX_RUN:
			begin
				if (auto_cts && cts_sync_reg)
					flow_next = tx_active ? TX_DRAIN : TX_HALTED;
			end
			TX_DRAIN:
			begin
				if (!auto_cts || !cts_sync_reg)
					flow_next = TX_RUN;
				else if (!tx_active)
					flow_next = TX_HALTED;
			end
			TX_HALTED:
			begin
				if (!auto_cts || !cts_sync_reg)
					flow_next = TX_RUN;
			end
			default:
				flow_next = TX_RUN;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flow_reg <= TX_RUN;
		else
			flow_reg <= flow_next;
	end

	assign tx_halt = (flow_reg == TX_HALTED);

	always_comb
	begin
		modem_line_status = `MSS_BYTE_ZERO;
		modem_line_status[`MSR_DCTS_BIT] = delta_cts_reg;
		modem_line_status[`MSR_CTS_BIT] = ~cts_sync_reg;
		// unsupported: no delta, level is complement of a tied-high pin
		modem_line_status[`MSR_DDSR_BIT] = 1'b0;
		modem_line_status[`MSR_DRI_BIT] = 1'b0;
		modem_line_status[`MSR_DCD_BIT] = 1'b0;
		modem_line_status[`MSR_DSR_BIT] = ~dsr_pin_n;
		modem_line_status[`MSR_RI_BIT] = ~ri_pin_n;
		modem_line_status[`MSR_CD_BIT] = ~cd_pin_n;
	end

	assign scratch_pad = scr_reg;
	assign interrupt_enable_register = ier_reg;
	assign enhanced_feature_register = efr_reg;
	assign modem_control_register = mcr_reg;
	assign ms_irq = delta_cts_reg & ier_reg[`IER_MSI_BIT];

endmodule : uart_mss_channel

/* uart_mss_defs.svh */
// register offsets, field positions and reset values of the modem status block
`ifndef UART_MSS_DEFS_SVH
`define UART_MSS_DEFS_SVH

`define MSS_ADDR_W 8
`define MSS_DATA_W 8
`define MSS_CHANNELS 8
`define MSS_GLOBAL_BIT 7
`define MSS_CH_HI 6
`define MSS_CH_LO 4
`define MSS_OFS_HI 3
`define MSS_OFS_LO 0

`define MSS_OFS_MSR 4'h0
`define MSS_OFS_SCR 4'h1
`define MSS_OFS_IER 4'h2
`define MSS_OFS_EFR 4'h3
`define MSS_OFS_MCR 4'h4

`define MSS_OFS_IRQ_STAT 4'h0
`define MSS_OFS_IRQ_MASK 4'h1
`define MSS_OFS_TX_HALT 4'h2

`define MSR_DCTS_BIT 0
`define MSR_DDSR_BIT 1
`define MSR_DRI_BIT 2
`define MSR_DCD_BIT 3
`define MSR_CTS_BIT 4
`define MSR_DSR_BIT 5
`define MSR_RI_BIT 6
`define MSR_CD_BIT 7
`define IER_MSI_BIT 3
`define EFR_AUTO_CTS_BIT 7
`define MCR_FLOW_SEL_BIT 2

`define MSS_BYTE_ZERO 8'h00
`define MSS_PIN_IDLE 1'b1

`endif

/* uart_mss_pkg.sv */
// types shared by the modem status and scratch block
package uart_mss_pkg;

	typedef enum logic [1:0]
	{
		TX_RUN,
		TX_DRAIN,
		TX_HALTED
	} tx_flow_type;

	typedef logic [7:0] byte_type;

endpackage : uart_mss_pkg

/* uart_modem_status_scratch.sv */
// modem status and scratch registers of an eight-channel serial controller
//
// Overview of operation
// - Eight channels, each with its own modem status and scratch register.
// - Modem status shows the present cts level and a changed-since-read flag.
// - Status bit 0 sets on any cts change; it reads 0 otherwise and after reset.
// - Bit 0 set with enable bit 3 on raises a modem status interrupt.
// - Status bits for dsr, ri and cd are unsupported and read inactive.
// - Dsr, ri and cd inputs are tied to the inactive high level.
// - Auto cts needs both enhanced feature bit 7 and modem control bit 2.
// - With auto cts, cts high stops transmit after the current character.
// - With auto cts, cts low lets the stopped transmitter resume.
// - Without auto flow control, status bit 4 is the inverse of the cts pin.
// - Eight-bit scratch per channel, read and write, no effect on operation.
`timescale 1ns/1ps
`include "uart_mss_defs.svh"

module uart_modem_status_scratch #(
	parameter int CHANNELS = `MSS_CHANNELS
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input wire logic [`MSS_ADDR_W-1:0] ADDR,
	input wire uart_mss_pkg::byte_type WR_DATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output uart_mss_pkg::byte_type RD_DATA,
	// modem pins, active low
	input wire logic [CHANNELS-1:0] CTS_N,
	// transmitter handshake
	input wire logic [CHANNELS-1:0] TX_ACTIVE,
	output logic [CHANNELS-1:0] TX_HALT,
	// interrupts
	output logic [CHANNELS-1:0] MS_IRQ,
	output logic IRQ
);
	import uart_mss_pkg::*;

	byte_type msr_w [CHANNELS];
	byte_type scr_w [CHANNELS];
	byte_type ier_w [CHANNELS];
	byte_type efr_w [CHANNELS];
	byte_type mcr_w [CHANNELS];
	logic [CHANNELS-1:0] ms_irq_w;
	logic [CHANNELS-1:0] ms_irq_prev_reg;
	logic [CHANNELS-1:0] irq_stat_reg;
	logic [CHANNELS-1:0] irq_mask_reg;
	logic [CHANNELS-1:0] irq_rise;
	byte_type rd_data_reg;
	byte_type rd_next;
	logic global_sel;
	logic [`MSS_CH_HI-`MSS_CH_LO:0] ch_sel;
	logic [`MSS_OFS_HI:0] ofs;

	assign global_sel = ADDR[`MSS_GLOBAL_BIT];
	assign ch_sel = ADDR[`MSS_CH_HI:`MSS_CH_LO];
	assign ofs = ADDR[`MSS_OFS_HI:`MSS_OFS_LO];

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : gen_ch
			logic hit;
			assign hit = !global_sel && (ch_sel == (`MSS_CH_HI-`MSS_CH_LO+1)'(g));
			uart_mss_channel u_ch
			(
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.cts_pin_n(CTS_N[g]),
				.tx_active(TX_ACTIVE[g]),
				.tx_halt(TX_HALT[g]),
				.rd_msr(RD_STB && hit && ofs == `MSS_OFS_MSR),
				.wr_scr(WR_STB && hit && ofs == `MSS_OFS_SCR),
				.wr_ier(WR_STB && hit && ofs == `MSS_OFS_IER),
				.wr_efr(WR_STB && hit && ofs == `MSS_OFS_EFR),
				.wr_mcr(WR_STB && hit && ofs == `MSS_OFS_MCR),
				.wr_data(WR_DATA),
				.modem_line_status(msr_w[g]),
				.scratch_pad(scr_w[g]),
				.interrupt_enable_register(ier_w[g]),
				.enhanced_feature_register(efr_w[g]),
				.modem_control_register(mcr_w[g]),
				.ms_irq(ms_irq_w[g])
			);
		end
	endgenerate

	assign MS_IRQ = ms_irq_w;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			ms_irq_prev_reg <= '0;
		else
			ms_irq_prev_reg <= ms_irq_w;
	end

	assign irq_rise = ms_irq_w & ~ms_irq_prev_reg;

	// sticky summary: a new event in the clearing write still sets its bit
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			irq_stat_reg <= '0;
		else if (WR_STB && global_sel && ofs == `MSS_OFS_IRQ_STAT)
			irq_stat_reg <= (irq_stat_reg & ~WR_DATA[CHANNELS-1:0]) | irq_rise;
		else
			irq_stat_reg <= irq_stat_reg | irq_rise;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			irq_mask_reg <= '0;
		else if (WR_STB && global_sel && ofs == `MSS_OFS_IRQ_MASK)
			irq_mask_reg <= WR_DATA[CHANNELS-1:0];
	end

	assign IRQ = |(irq_stat_reg & irq_mask_reg);

	always_comb
	begin
		rd_next = `MSS_BYTE_ZERO;
		if (global_sel)
		begin
			case (ofs)
				`MSS_OFS_IRQ_STAT: rd_next[CHANNELS-1:0] = irq_stat_reg;
				`MSS_OFS_IRQ_MASK: rd_next[CHANNELS-1:0] = irq_mask_reg;
				`MSS_OFS_TX_HALT: rd_next[CHANNELS-1:0] = TX_HALT;
				default: rd_next = `MSS_BYTE_ZERO;
			endcase
		end
		else if (int'(ch_sel) < CHANNELS)
		begin
			case (ofs)
				`MSS_OFS_MSR: rd_next = msr_w[ch_sel];
				`MSS_OFS_SCR: rd_next = scr_w[ch_sel];
				`MSS_OFS_IER: rd_next = ier_w[ch_sel];
				`MSS_OFS_EFR: rd_next = efr_w[ch_sel];
				`MSS_OFS_MCR: rd_next = mcr_w[ch_sel];
				default: rd_next = `MSS_BYTE_ZERO;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			rd_data_reg <= `MSS_BYTE_ZERO;
		else if (RD_STB)
			rd_data_reg <= rd_next;
		else
			rd_data_reg <= `MSS_BYTE_ZERO;
	end

	assign RD_DATA = rd_data_reg;

endmodule : uart_modem_status_scratch

/* uart_mss_assertions.sv */
// checker for the modem status and scratch block, watching channel 0
`timescale 1ns/1ps
module uart_mss_checker #(
	parameter int CHANNELS = 8
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire uart_mss_pkg::byte_type WR_DATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire uart_mss_pkg::byte_type RD_DATA,
	// pins, transmitter and interrupts
	input wire logic [CHANNELS-1:0] CTS_N,
	input wire logic [CHANNELS-1:0] TX_ACTIVE,
	input wire logic [CHANNELS-1:0] TX_HALT,
	input wire logic [CHANNELS-1:0] MS_IRQ,
	input wire logic IRQ
);
	import uart_mss_pkg::*;
	byte_type scr_reg;
	logic ier_reg;
	logic efr_reg;
	logic mcr_reg;
	logic auto_on;
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			{ier_reg, efr_reg, mcr_reg} <= 3'h0;
			scr_reg <= 8'h00;
		end
		else if (WR_STB)
		begin
			case (ADDR)
				8'h01: scr_reg <= WR_DATA;
				8'h02: ier_reg <= WR_DATA[3];
				8'h03: efr_reg <= WR_DATA[7];
				8'h04: mcr_reg <= WR_DATA[2];
				default: ;
			endcase
		end
	end
	assign auto_on = efr_reg & mcr_reg;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// a read in the last cycles must not race the change flag
	sequence s_cts_move;
		ier_reg && $changed(CTS_N[0]) ##1 ($stable(CTS_N[0]) && !RD_STB && ier_reg)[*4];
	endsequence
	sequence s_quiet_read;
		$stable(CTS_N[0])[*6] ##0 (RD_STB && ADDR == 8'h00);
	endsequence
	property p_delta_irq; s_cts_move |-> MS_IRQ[0]; endproperty
	a_delta_irq: assert property (p_delta_irq) else $error("no irq after cts change");
	property p_irq_gate; !ier_reg && !$past(ier_reg) |-> !MS_IRQ[0]; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
	property p_read_clear; s_quiet_read |-> ##2 !MS_IRQ[0]; endproperty
	a_read_clear: assert property (p_read_clear) else $error("flag kept after read");
	property p_level; s_quiet_read |=> RD_DATA[4] == !$past(CTS_N[0]); endproperty
	a_level: assert property (p_level) else $error("cts level bit wrong");
	property p_spare;
		RD_STB && ADDR == 8'h00 |=> RD_DATA[7:5] == 3'h0 && RD_DATA[3:1] == 3'h0;
	endproperty
	a_spare: assert property (p_spare) else $error("unused status bit set");
	property p_scratch; RD_STB && ADDR == 8'h01 |=> RD_DATA == scr_reg; endproperty
	a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
	property p_halt_on; (auto_on && CTS_N[0] && !TX_ACTIVE[0])[*5] |-> TX_HALT[0]; endproperty
	a_halt_on: assert property (p_halt_on) else $error("no halt on cts high");
	property p_halt_wait; $rose(TX_HALT[0]) |-> !$past(TX_ACTIVE[0]); endproperty
	a_halt_wait: assert property (p_halt_wait) else $error("halt cut a character");
	property p_auto_off; (!auto_on)[*3] |-> !TX_HALT[0]; endproperty
	a_auto_off: assert property (p_auto_off) else $error("halt without auto mode");
	property p_resume; (!CTS_N[0])[*4] |-> !TX_HALT[0]; endproperty
	a_resume: assert property (p_resume) else $error("halt kept on cts low");
endmodule : uart_mss_checker

bind uart_modem_status_scratch uart_mss_checker #(.CHANNELS(CHANNELS)) u_chk (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
	.RD_DATA(RD_DATA), .CTS_N(CTS_N), .TX_ACTIVE(TX_ACTIVE), .TX_HALT(TX_HALT),
	.MS_IRQ(MS_IRQ), .IRQ(IRQ));

/* uart_mss_far.sv */
// far side model: modem driving cts and transmitters sending characters
`timescale 1ns/1ps
module uart_mss_far #(
	parameter int CHAR_LEN = 6
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// requests from the bench
	input wire logic [7:0] cts_want_n,
	input wire logic [7:0] send,
	// lines to the block
	input wire logic [7:0] tx_halt,
	output logic [7:0] cts_n,
	output logic [7:0] tx_active
);
	logic [3:0] cnt [8];
	always_ff @(posedge clk)
	begin
		cts_n <= rst_n ? cts_want_n : 8'hFF;
		for (int i = 0; i < 8; i++)
		begin
			if (!rst_n)
				cnt[i] <= 4'h0;
			else if (cnt[i] != 4'h0)
				cnt[i] <= cnt[i] - 4'h1;
			else if (send[i] && !tx_halt[i])
				cnt[i] <= CHAR_LEN[3:0];
		end
	end
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			tx_active[i] = cnt[i] != 4'h0;
	end
endmodule : uart_mss_far

/* tb_uart_modem_status_scratch.sv */
// self-checking bench for the modem status and scratch block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_uart_modem_status_scratch;
	import uart_mss_pkg::*;
	logic CLK_SYS, RST_N, WR_STB, RD_STB, IRQ, rd_was;
	logic [7:0] ADDR, cts_want_n, send, CTS_N, TX_ACTIVE, TX_HALT, MS_IRQ;
	byte_type WR_DATA, RD_DATA, d, exp_v;
	byte_type exp_q[$];
	int err_count, check_count;
	initial
	begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	uart_modem_status_scratch DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR),
		.WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .CTS_N(CTS_N),
		.TX_ACTIVE(TX_ACTIVE), .TX_HALT(TX_HALT), .MS_IRQ(MS_IRQ), .IRQ(IRQ));
	uart_mss_far u_far (.clk(CLK_SYS), .rst_n(RST_N), .cts_want_n(cts_want_n), .send(send),
		.tx_halt(TX_HALT), .cts_n(CTS_N), .tx_active(TX_ACTIVE));
	// read data stand only in the cycle after the strobe
	always @(posedge CLK_SYS)
	begin
		// pop once: the macro names its expected value twice
		if (rd_was)
		begin
			exp_v = exp_q.pop_front();
			`CHK(RD_DATA, exp_v)
		end
		rd_was = RD_STB;
	end
	task wr(input logic [7:0] a, input byte_type v);
		@(posedge CLK_SYS);
		ADDR <= a;
		WR_DATA <= v;
		WR_STB <= 1'b1;
		@(posedge CLK_SYS);
		WR_STB <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input byte_type v);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD_STB <= 1'b1;
		exp_q.push_back(v);
		@(posedge CLK_SYS);
		RD_STB <= 1'b0;
	endtask : rd
	task settle(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask : settle
	task wait_halt(input logic v);
		int n;
		n = 0;
		while (TX_HALT[0] !== v && n < 40)
		begin
			settle(1);
			n++;
		end
		`CHK(TX_HALT[0], v)
		if (n == 40)
			print_verdict();
	endtask : wait_halt
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		{RST_N, WR_STB, RD_STB, rd_was, ADDR, WR_DATA, send} = '0;
		cts_want_n = 8'hFF;
		err_count = 0;
		check_count = 0;
		void'($urandom(32'hF2FDC5F7));
		repeat (8) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		for (int ch = 0; ch < 8; ch++)
		begin
			d = 8'($urandom);
			wr({1'b0, ch[2:0], 4'h1}, d);
			rd({1'b0, ch[2:0], 4'h1}, d);
			rd({1'b0, ch[2:0], 4'h0}, 8'h00);
		end
		rd(8'h0F, 8'h00);
		$display("test registers finished");
		wr(8'h02, 8'h08);
		wr(8'h81, 8'h01);
		cts_want_n[0] <= 1'b0;
		settle(6);
		`CHK(MS_IRQ, 8'h01)
		`CHK(IRQ, 1'b1)
		rd(8'h00, 8'h11);
		rd(8'h00, 8'h10);
		rd(8'h80, 8'h01);
		wr(8'h80, 8'h01);
		wr(8'h81, 8'h00);
		settle(2);
		`CHK({MS_IRQ[0], IRQ}, 2'b00)
		cts_want_n[0] <= 1'b1;
		settle(6);
		`CHK({MS_IRQ[0], IRQ}, 2'b10)
		rd(8'h00, 8'h01);
		$display("test status finished");
		send <= 8'h01;
		wr(8'h03, 8'h80);
		settle(12);
		`CHK(TX_HALT, 8'h00)
		wr(8'h04, 8'h04);
		wait_halt(1'b1);
		rd(8'h82, 8'h01);
		settle(12);
		`CHK(TX_ACTIVE, 8'h00)
		cts_want_n[0] <= 1'b0;
		wait_halt(1'b0);
		settle(3);
		`CHK(TX_ACTIVE, 8'h01)
		cts_want_n[0] <= 1'b1;
		wait_halt(1'b1);
		wr(8'h03, 8'h00);
		wait_halt(1'b0);
		$display("test flow finished");
		settle(4);
		print_verdict();
	end
endmodule : tb_uart_modem_status_scratch
